// File: mis_consts.svh
// Constants for the interrupt sequencer: register indices, field positions, vectors.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MIS_CONSTS_SVH
`define MIS_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index
`define MIS_IDX_PIN_B_CTRL 8'h0A
`define MIS_IDX_PIN_C_CTRL 8'h0B
`define MIS_IDX_OPTION 8'h1D
`define MIS_IDX_TICK_CTRL 8'h20
`define MIS_IDX_SEQ_STATUS 8'h21

// Pin control/status fields
`define MIS_PIN_FLAG_BIT 5
`define MIS_PIN_ENABLE_BIT 4
`define MIS_PIN_LEVEL_SEL_BIT 3
`define MIS_PIN_POLARITY_BIT 2
`define MIS_PIN_CLEAR_BIT 1
`define MIS_PIN_LEVEL_READ_BIT 0
`define MIS_PIN_CTRL_RESET 8'h00

// Option register field
`define MIS_OPT_EDGE_ONLY_BIT 1

// Core tick control/status fields
`define MIS_TICK_WRAP_FLAG_BIT 7
`define MIS_TICK_PERIODIC_FLAG_BIT 6
`define MIS_TICK_WRAP_EN_BIT 5
`define MIS_TICK_PERIODIC_EN_BIT 4
`define MIS_TICK_COUNT_MAX 8'hFF
`define MIS_TICK_COUNT_MIN 8'h00

// Vector locations, high byte first
`define MIS_VEC_RESET_HI 16'h3FFE
`define MIS_VEC_RESET_LO 16'h3FFF
`define MIS_VEC_TRAP_HI 16'h3FFC
`define MIS_VEC_TRAP_LO 16'h3FFD
`define MIS_VEC_EXT_HI 16'h3FFA
`define MIS_VEC_EXT_LO 16'h3FFB
`define MIS_VEC_TICK_HI 16'h3FF8
`define MIS_VEC_TICK_LO 16'h3FF9
`define MIS_VEC_I2C_HI 16'h3FF6
`define MIS_VEC_I2C_LO 16'h3FF7
`define MIS_VEC_PTIMER_HI 16'h3FF4
`define MIS_VEC_PTIMER_LO 16'h3FF5

`endif

// File: mis_pkg.sv
// Types shared by the interrupt sequencer modules.
// Assumes mis_consts.svh is on the include path.
package mis_pkg;
  `include "mis_consts.svh"

  typedef enum logic [1:0] {
    MIS_SEQ_BOOT,
    MIS_SEQ_RUN,
    MIS_SEQ_STOP,
    MIS_SEQ_WAIT
  } mis_seq_state_t;

  typedef enum logic [2:0] {
    MIS_SRC_RESET,
    MIS_SRC_TRAP,
    MIS_SRC_EXT,
    MIS_SRC_TICK,
    MIS_SRC_I2C,
    MIS_SRC_PTIMER
  } mis_source_t;
endpackage

// File: mis_pin_if.sv
// Carrier between the sequencer and one edge/level request detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface mis_pin_if;
  logic level_sel;
  logic polarity_sel;
  logic enable;
  logic clear;
  logic flag;
  logic level;
  logic request;

  modport owner(output level_sel, output polarity_sel, output enable, output clear,
                input flag, input level, input request);
  modport detector(input level_sel, input polarity_sel, input enable, input clear,
                   output flag, output level, output request);
endinterface

// File: mis_pin_detect.sv
// Edge or edge-and-level request detector for one external request pin.
// Assumes the pin is sampled on pclk; the configuration comes from the owner.
`timescale 1ns/1ps
module mis_pin_detect
  import mis_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  mis_pin_if.detector pif
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic flag_q;
  logic edge_hit;
  logic level_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Polarity picks the edge, level select adds the matching level
  assign edge_hit = pif.polarity_sel ? (sync2_q & ~prev_q) : (~sync2_q & prev_q);
  assign level_hit = pif.level_sel & (sync2_q == pif.polarity_sel);

  // A new event in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (edge_hit | level_hit) begin
      flag_q <= 1'b1;
    end else if (pif.clear) begin
      flag_q <= 1'b0;
    end
  end

  assign pif.flag = flag_q;
  assign pif.level = sync2_q;
  assign pif.request = flag_q & pif.enable;
endmodule

// File: mis_irq_seq.sv
// Interrupt request sequencer: pin detectors, APB registers, arbitration and sleep control.
// Assumes an APB master on pclk and a CPU core that reports fetch, completion and mask writes.
// Function
// - Soft trap is taken regardless of the global mask bit.
// - Unmasked, trap follows requests pending at its fetch, precedes later ones.
// - Soft trap vectors through 3FFC and 3FFD.
// - Mask set holds off all maskable requests; clearing lets pending ones through.
// - Pin a latch clears when serviced; a further pulse may latch meanwhile.
// - Pin a request latches after its falling edge, synchronised before service.
// - Option bit 1 clear gives edge-and-level, set gives edge-only on pin a.
// - Pin a trigger select resets clear and accepts only one write.
// - All three external pins share the vector at 3FFA and 3FFB.
// - Bit 4 of each pin b/c register enables that pin's request.
// - Bit 5 is a per-pin flag set by a valid event.
// - Level and polarity bits choose falling/rising edge, optionally plus level.
// - Writing one to the clear bit clears the flag; it reads zero.
// - Bit 0 returns the present pin level.
// - Core tick requests via 3FF8/3FF9 when an enabled flag is set.
// - Wrap flag sets when the tick counter rolls from FF to 00.
// - Five enabled programmable timer flags share vector 3FF4/3FF5; timer runs in wait.
// - Enabled I2C flags request via vector 3FF6 and 3FF7.
// - Reset vectors through 3FFE/3FFF and sets the global mask.
// - Stop turns the oscillator off until an external request or reset.
// - Wait stops CPU clocks, keeps core tick running, exits on request.
// - Priority: reset, trap, external pins, core tick, I2C, programmable timer.
// - Hardware requests wait for instruction end, then need unmasked and enabled.
// - Taking an interrupt saves registers and sets the mask; return restores.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "mis_consts.svh"
module mis_irq_seq
  import mis_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PT_FLAGS = 5,
  parameter int I2C_FLAGS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_request_pin_a_n,
  input wire logic ext_request_pin_b,
  input wire logic ext_request_pin_c,
  input wire logic [7:0] tick_count,
  input wire logic periodic_tick_pulse,
  input wire logic [PT_FLAGS-1:0] prog_timer_flags,
  input wire logic [PT_FLAGS-1:0] prog_timer_enables,
  input wire logic [I2C_FLAGS-1:0] i2c_flags,
  input wire logic [I2C_FLAGS-1:0] i2c_enables,
  input wire logic cpu_trap_fetch,
  input wire logic cpu_instr_done,
  input wire logic cpu_mask_wr,
  input wire logic cpu_mask_wdata,
  input wire logic cpu_stop_req,
  input wire logic cpu_wait_req,
  output logic vec_take,
  output logic stack_save,
  output logic [15:0] vec_hi_addr,
  output logic [15:0] vec_lo_addr,
  output logic mask_bit,
  output logic osc_enable,
  output logic cpu_clk_enable,
  output logic tick_clk_enable,
  output logic prog_timer_clk_enable
);
  localparam int NPIN = 2;

  mis_seq_state_t state_q;
  logic [NPIN-1:0] pin_en_q;
  logic [NPIN-1:0] pin_lv_q;
  logic [NPIN-1:0] pin_pol_q;
  logic [NPIN-1:0] pin_clr;
  logic [NPIN-1:0] pin_flag;
  logic [NPIN-1:0] pin_level;
  logic [NPIN-1:0] pin_req;
  logic a_sync1_q, a_sync2_q, a_prev_q, a_latch_q;
  logic edge_only_q;
  logic opt_written_q;
  logic mask_q;
  logic trap_pend_q;
  logic [3:0] snap_q;
  logic tick_wrap_q, tick_per_q, tick_wrap_en_q, tick_per_en_q;
  logic [7:0] tick_prev_q;
  logic vec_take_q;
  logic stack_save_q;
  logic [15:0] vec_hi_q;
  logic [15:0] vec_lo_q;
  logic [31:0] prdata_q;
  logic ext_req, tick_req, i2c_req, pt_req;
  logic [3:0] hw_req;
  logic [3:0] hw_sel;
  logic take_trap, take_hw, take_ext;
  logic wr;
  logic rd_setup;
  logic [7:0] idx;
  logic hit;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [7:0] pin_reg [NPIN];

  // Pin b and c detectors
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      mis_pin_if pif();
      assign pif.level_sel = pin_lv_q[g];
      assign pif.polarity_sel = pin_pol_q[g];
      assign pif.enable = pin_en_q[g];
      assign pif.clear = pin_clr[g];
      assign pin_flag[g] = pif.flag;
      assign pin_level[g] = pif.level;
      assign pin_req[g] = pif.request;
      mis_pin_detect u_det (
        .pclk(pclk),
        .presetn(presetn),
        .pin(g == 0 ? ext_request_pin_b : ext_request_pin_c),
        .pif(pif)
      );
      assign pin_reg[g] = {2'b00, pin_flag[g], pin_en_q[g], pin_lv_q[g], pin_pol_q[g],
                           1'b0, pin_level[g]};
    end
  endgenerate

  // APB slave: zero wait states, error on unmapped index
  assign idx = 8'(paddr[ADDR_W-1:2]);
  assign hit = (idx == `MIS_IDX_PIN_B_CTRL) || (idx == `MIS_IDX_PIN_C_CTRL) || (idx == `MIS_IDX_OPTION) ||
               (idx == `MIS_IDX_TICK_CTRL) || (idx == `MIS_IDX_SEQ_STATUS);
  assign wr = psel & penable & pwrite & hit;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always_comb begin
    rbyte = 8'h00;
    case (idx)
      `MIS_IDX_PIN_B_CTRL: rbyte = pin_reg[0];
      `MIS_IDX_PIN_C_CTRL: rbyte = pin_reg[1];
      `MIS_IDX_OPTION: rbyte = {6'b00_0000, edge_only_q, 1'b0};
      `MIS_IDX_TICK_CTRL: rbyte = {tick_wrap_q, tick_per_q, tick_wrap_en_q, tick_per_en_q, 4'h0};
      `MIS_IDX_SEQ_STATUS: rbyte = {hw_req, state_q == MIS_SEQ_WAIT, state_q == MIS_SEQ_STOP,
                                    trap_pend_q, mask_q};
      default: rbyte = 8'h00;
    endcase
  end

  // Read data is captured in the setup cycle so it comes from flops in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_q <= {24'h00_0000, rbyte};
    end
  end
  assign prdata = prdata_q;

  // Pin b/c configuration; clear is a write-only strobe
  always_comb begin
    pin_clr = '0;
    if (wr && idx == `MIS_IDX_PIN_B_CTRL) begin
      pin_clr[0] = wbyte[`MIS_PIN_CLEAR_BIT];
    end
    if (wr && idx == `MIS_IDX_PIN_C_CTRL) begin
      pin_clr[1] = wbyte[`MIS_PIN_CLEAR_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_en_q <= '0;
      pin_lv_q <= '0;
      pin_pol_q <= '0;
    end else if (wr && (idx == `MIS_IDX_PIN_B_CTRL || idx == `MIS_IDX_PIN_C_CTRL)) begin
      pin_en_q[idx[0]] <= wbyte[`MIS_PIN_ENABLE_BIT];
      pin_lv_q[idx[0]] <= wbyte[`MIS_PIN_LEVEL_SEL_BIT];
      pin_pol_q[idx[0]] <= wbyte[`MIS_PIN_POLARITY_BIT];
    end
  end

  // Option bit is write-once; only a reset reopens it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_only_q <= 1'b0;
      opt_written_q <= 1'b0;
    end else if (wr && idx == `MIS_IDX_OPTION && !opt_written_q) begin
      edge_only_q <= wbyte[`MIS_OPT_EDGE_ONLY_BIT];
      opt_written_q <= 1'b1;
    end
  end

  // Pin a: synchronise, then latch on the falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_sync1_q <= 1'b1;
      a_sync2_q <= 1'b1;
      a_prev_q <= 1'b1;
    end else begin
      a_sync1_q <= ext_request_pin_a_n;
      a_sync2_q <= a_sync1_q;
      a_prev_q <= a_sync2_q;
    end
  end

  // A fresh edge during the service clear is kept for the next service
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_latch_q <= 1'b0;
    end else if (a_prev_q && !a_sync2_q) begin
      a_latch_q <= 1'b1;
    end else if (take_ext) begin
      a_latch_q <= 1'b0;
    end
  end

  // Core tick flags; written ones clear them, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_prev_q <= `MIS_TICK_COUNT_MIN;
      tick_wrap_q <= 1'b0;
      tick_per_q <= 1'b0;
      tick_wrap_en_q <= 1'b0;
      tick_per_en_q <= 1'b0;
    end else begin
      tick_prev_q <= tick_count;
      if (tick_prev_q == `MIS_TICK_COUNT_MAX && tick_count == `MIS_TICK_COUNT_MIN) begin
        tick_wrap_q <= 1'b1;
      end else if (wr && idx == `MIS_IDX_TICK_CTRL && wbyte[`MIS_TICK_WRAP_FLAG_BIT]) begin
        tick_wrap_q <= 1'b0;
      end
      if (periodic_tick_pulse) begin
        tick_per_q <= 1'b1;
      end else if (wr && idx == `MIS_IDX_TICK_CTRL && wbyte[`MIS_TICK_PERIODIC_FLAG_BIT]) begin
        tick_per_q <= 1'b0;
      end
      if (wr && idx == `MIS_IDX_TICK_CTRL) begin
        tick_wrap_en_q <= wbyte[`MIS_TICK_WRAP_EN_BIT];
        tick_per_en_q <= wbyte[`MIS_TICK_PERIODIC_EN_BIT];
      end
    end
  end

  // Request sources, highest priority in the top bit
  assign ext_req = (a_latch_q | (~edge_only_q & ~a_sync2_q)) | (|pin_req);
  assign tick_req = (tick_wrap_q & tick_wrap_en_q) | (tick_per_q & tick_per_en_q);
  assign i2c_req = |(i2c_flags & i2c_enables);
  assign pt_req = |(prog_timer_flags & prog_timer_enables);
  assign hw_req = {ext_req, tick_req, i2c_req, pt_req};

  // Trap pending from fetch until taken; snapshot marks requests older than the trap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_pend_q <= 1'b0;
      snap_q <= 4'h0;
    end else if (cpu_trap_fetch) begin
      trap_pend_q <= 1'b1;
      snap_q <= hw_req;
    end else if (take_trap) begin
      trap_pend_q <= 1'b0;
      snap_q <= 4'h0;
    end
  end

  // Only at an instruction boundary; a trap bypasses the mask
  always_comb begin
    take_trap = 1'b0;
    take_hw = 1'b0;
    hw_sel = 4'h0;
    if (state_q == MIS_SEQ_RUN && cpu_instr_done) begin
      if (trap_pend_q && (mask_q || (hw_req & snap_q) == 4'h0)) begin
        take_trap = 1'b1;
      end else if (!mask_q) begin
        hw_sel = trap_pend_q ? (hw_req & snap_q) : hw_req;
        take_hw = |hw_sel;
      end
    end
  end
  assign take_ext = take_hw & hw_sel[3];

  // Sequencer and sleep states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= MIS_SEQ_BOOT;
    end else begin
      case (state_q)
        MIS_SEQ_BOOT: state_q <= MIS_SEQ_RUN;
        MIS_SEQ_RUN: begin
          if (cpu_stop_req) begin
            state_q <= MIS_SEQ_STOP;
          end else if (cpu_wait_req) begin
            state_q <= MIS_SEQ_WAIT;
          end
        end
        MIS_SEQ_STOP: begin
          if (ext_req) begin
            state_q <= MIS_SEQ_RUN;
          end
        end
        MIS_SEQ_WAIT: begin
          if (ext_req | tick_req | pt_req | i2c_req) begin
            state_q <= MIS_SEQ_RUN;
          end
        end
        default: state_q <= MIS_SEQ_BOOT;
      endcase
    end
  end

  // Sleep gating; the programmable timer keeps its clock in wait
  assign osc_enable = state_q != MIS_SEQ_STOP;
  assign cpu_clk_enable = state_q == MIS_SEQ_RUN || state_q == MIS_SEQ_BOOT;
  assign tick_clk_enable = state_q != MIS_SEQ_STOP;
  assign prog_timer_clk_enable = state_q != MIS_SEQ_STOP;

  // Global mask: set at reset and on every take, else written by the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 1'b1;
    end else if (take_trap || take_hw) begin
      mask_q <= 1'b1;
    end else if (cpu_mask_wr) begin
      mask_q <= cpu_mask_wdata;
    end
  end
  assign mask_bit = mask_q;

  // Vector out, one pulse per take; the core stacks on stack_save
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_take_q <= 1'b0;
      stack_save_q <= 1'b0;
      vec_hi_q <= `MIS_VEC_RESET_HI;
      vec_lo_q <= `MIS_VEC_RESET_LO;
    end else begin
      vec_take_q <= (state_q == MIS_SEQ_BOOT) | take_trap | take_hw;
      stack_save_q <= take_trap | take_hw;
      if (state_q == MIS_SEQ_BOOT) begin
        vec_hi_q <= `MIS_VEC_RESET_HI;
        vec_lo_q <= `MIS_VEC_RESET_LO;
      end else if (take_trap) begin
        vec_hi_q <= `MIS_VEC_TRAP_HI;
        vec_lo_q <= `MIS_VEC_TRAP_LO;
      end else if (take_hw && hw_sel[3]) begin
        vec_hi_q <= `MIS_VEC_EXT_HI;
        vec_lo_q <= `MIS_VEC_EXT_LO;
      end else if (take_hw && hw_sel[2]) begin
        vec_hi_q <= `MIS_VEC_TICK_HI;
        vec_lo_q <= `MIS_VEC_TICK_LO;
      end else if (take_hw && hw_sel[1]) begin
        vec_hi_q <= `MIS_VEC_I2C_HI;
        vec_lo_q <= `MIS_VEC_I2C_LO;
      end else if (take_hw) begin
        vec_hi_q <= `MIS_VEC_PTIMER_HI;
        vec_lo_q <= `MIS_VEC_PTIMER_LO;
      end
    end
  end
  assign vec_take = vec_take_q;
  assign stack_save = stack_save_q;
  assign vec_hi_addr = vec_hi_q;
  assign vec_lo_addr = vec_lo_q;
endmodule

// File: mis_irq_seq_checker.sv
// Concurrent checks on the interrupt sequencer's top ports.
// Assumes one clock domain and a bind from the bench top file.
`timescale 1ns/1ps
module mis_irq_seq_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_instr_done,
  input wire logic cpu_stop_req,
  input wire logic vec_take,
  input wire logic stack_save,
  input wire logic [15:0] vec_hi_addr,
  input wire logic [15:0] vec_lo_addr,
  input wire logic mask_bit,
  input wire logic osc_enable,
  input wire logic cpu_clk_enable,
  input wire logic tick_clk_enable,
  input wire logic prog_timer_clk_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  sequence s_take; vec_take && stack_save; endsequence
  apb_ready_a:
    assert property (s_setup ##1 s_access |-> pready) else $error("pready low in access phase");
  slverr_phase_a:
    assert property (pslverr |-> psel && penable) else $error("pslverr outside access phase");
  reset_vec_a:
    assert property (vec_take && !stack_save |-> vec_hi_addr == 16'h3FFE && vec_lo_addr == 16'h3FFF && mask_bit)
    else $error("bad reset vector");
  take_mask_a:
    assert property (vec_take |-> mask_bit) else $error("mask clear after take");
  save_boundary_a:
    assert property (s_take |-> $past(cpu_instr_done)) else $error("take off instruction boundary");
  save_with_take_a:
    assert property (stack_save |-> vec_take) else $error("stack save without vector");
  masked_trap_a:
    assert property ((s_take and $past(mask_bit)) |-> vec_hi_addr == 16'h3FFC) else $error("masked take not trap");
  vec_pair_a:
    assert property (vec_take |-> vec_lo_addr == vec_hi_addr + 16'h0001) else $error("vector pair mismatch");
  // Guarded by past reset so a request in the boot cycle is not judged
  stop_enter_a:
    assert property (cpu_stop_req && $past(presetn) && osc_enable && cpu_clk_enable
      |=> !osc_enable && !cpu_clk_enable && !tick_clk_enable) else $error("stop did not halt clocks");
  wait_clk_a:
    assert property (!cpu_clk_enable && osc_enable |-> tick_clk_enable && prog_timer_clk_enable)
    else $error("timer clocks off in wait");
  cover property (s_take ##1 !vec_take);
endmodule

// File: mis_cpu_model.sv
// Core stand-in: instruction boundaries, trap fetch, mask restore, sleep requests.
// Assumes the bench calls pulse(); every vector taken is recorded here.
`timescale 1ns/1ps
module mis_cpu_model (
  input wire logic pclk,
  input wire logic vec_take,
  input wire logic [15:0] vec_hi_addr,
  output logic cpu_trap_fetch,
  output logic cpu_instr_done,
  output logic cpu_mask_wr,
  output logic cpu_mask_wdata,
  output logic cpu_stop_req,
  output logic cpu_wait_req
);
  logic [15:0] last_vec = 16'h0000;
  int takes = 0;
  initial begin
    {cpu_trap_fetch, cpu_instr_done, cpu_mask_wr, cpu_stop_req, cpu_wait_req} = 5'h00;
    cpu_mask_wdata = 1'b0; // Return always restores a cleared mask
  end
  always @(posedge pclk) begin
    if (vec_take) begin
      last_vec <= vec_hi_addr;
      takes <= takes + 1;
    end
  end
  // One-cycle strobe: 0 boundary, 1 trap fetch, 2 return, 3 stop, 4 wait
  task automatic pulse(input int c);
    @(posedge pclk);
    cpu_instr_done <= (c == 0);
    cpu_trap_fetch <= (c == 1);
    cpu_mask_wr <= (c == 2);
    cpu_stop_req <= (c == 3);
    cpu_wait_req <= (c == 4);
    @(posedge pclk);
    {cpu_instr_done, cpu_trap_fetch, cpu_mask_wr, cpu_stop_req, cpu_wait_req} <= 5'h00;
  endtask
endmodule

// File: test_mis_irq_seq.sv
// Self-checking bench: APB master, request pins and timer sources, core stand-in.
// Assumes package, interface, design, checker and core model compiled first.
`timescale 1ns/1ps
module test_mis_irq_seq;
  logic pclk = 1'b0, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic ext_request_pin_a_n, ext_request_pin_b, ext_request_pin_c;
  logic periodic_tick_pulse;
  logic [7:0] tick_count;
  logic [4:0] prog_timer_flags, prog_timer_enables;
  logic [3:0] i2c_flags, i2c_enables;
  logic cpu_trap_fetch, cpu_instr_done, cpu_mask_wr, cpu_mask_wdata, cpu_stop_req, cpu_wait_req;
  logic vec_take, stack_save, mask_bit, osc_enable, cpu_clk_enable, tick_clk_enable, prog_timer_clk_enable;
  logic [15:0] vec_hi_addr, vec_lo_addr;
  logic [31:0] seed = 32'h0001_3CC5;
  int err_count = 0, cmp_count = 0, cyc = 0;

  mis_irq_seq i_mis_irq_seq (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_request_pin_a_n, .ext_request_pin_b, .ext_request_pin_c, .tick_count, .periodic_tick_pulse,
    .prog_timer_flags, .prog_timer_enables, .i2c_flags, .i2c_enables, .cpu_trap_fetch, .cpu_instr_done,
    .cpu_mask_wr, .cpu_mask_wdata, .cpu_stop_req, .cpu_wait_req, .vec_take, .stack_save, .vec_hi_addr,
    .vec_lo_addr, .mask_bit, .osc_enable, .cpu_clk_enable, .tick_clk_enable, .prog_timer_clk_enable);
  mis_cpu_model i_mis_cpu_model (.pclk, .vec_take, .vec_hi_addr, .cpu_trap_fetch, .cpu_instr_done,
    .cpu_mask_wr, .cpu_mask_wdata, .cpu_stop_req, .cpu_wait_req);

  always #2 pclk = ~pclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] exp_ctl(input logic f, n, l, p, v);
    return {2'h0, f, n, l, p, 1'b0, v};
  endfunction
  function automatic logic [7:0] clks();
    return {4'h0, osc_enable, cpu_clk_enable, tick_clk_enable, prog_timer_clk_enable};
  endfunction

  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_vec(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Holds the whole request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d, output logic [7:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, i, d, r, e);
  endtask
  task automatic rd(input logic [5:0] i, output logic [7:0] r);
    logic e;
    apb(1'b0, i, 8'h00, r, e);
  endtask
  // Instruction boundary; expect 0000 when no vector may be taken
  task automatic take(input logic [15:0] e);
    int n;
    n = i_mis_cpu_model.takes;
    i_mis_cpu_model.pulse(0);
    repeat (2) @(posedge pclk);
    chk_vec("vector", e, (i_mis_cpu_model.takes == n + 1) ? i_mis_cpu_model.last_vec : 16'h0000);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    logic [7:0] r;
    logic e, l, p, v;
    logic [31:0] x;
    {presetn, psel, penable, pwrite, paddr, pwdata} <= '0;
    {ext_request_pin_a_n, ext_request_pin_b, ext_request_pin_c, periodic_tick_pulse} <= 4'h8;
    {tick_count, prog_timer_flags, prog_timer_enables, i2c_flags, i2c_enables} <= 26'h3FC_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk_vec("reset vector", 16'h3FFE, i_mis_cpu_model.last_vec);
    chk_reg("reset mask", 8'h01, {7'h00, mask_bit});
    rd(6'h1D, r);
    chk_reg("option reset", 8'h00, r);
    wr(6'h1D, 8'h02);
    wr(6'h1D, 8'h00);
    rd(6'h1D, r);
    chk_reg("option once", 8'h02, r);
    apb(1'b0, 6'h10, 8'h00, r, e);
    chk_reg("unmapped", 8'h01, {r[6:0], e});
    // Second write lands after the new sensitivity has settled
    for (int c = 0; c < 4; c++) begin
      l = c[1];
      p = c[0];
      ext_request_pin_b <= ~p;
      repeat (2) wr(6'h0A, exp_ctl(1'b0, 1'b1, l, p, 1'b0) | 8'h02);
      repeat (4) @(posedge pclk);
      rd(6'h0A, r);
      chk_reg("pin b idle", exp_ctl(1'b0, 1'b1, l, p, ~p), r);
      ext_request_pin_b <= p;
      repeat (4) @(posedge pclk);
      rd(6'h0A, r);
      chk_reg("pin b event", exp_ctl(1'b1, 1'b1, l, p, p), r);
      wr(6'h0A, exp_ctl(1'b0, 1'b1, l, p, 1'b0) | 8'h02);
      repeat (4) @(posedge pclk);
      rd(6'h0A, r);
      chk_reg("pin b held", exp_ctl(l, 1'b1, l, p, p), r);
    end
    take(16'h0000);
    i_mis_cpu_model.pulse(2);
    take(16'h3FFA);
    ext_request_pin_b <= 1'b0;
    repeat (2) wr(6'h0A, 8'h02);
    for (int k = 0; k < 6; k++) begin
      x = rnd();
      v = x[0];
      ext_request_pin_c <= v;
      repeat (4) @(posedge pclk);
      rd(6'h0B, r);
      chk_reg("pin c level", {7'h00, v}, r & 8'h01);
    end
    wr(6'h20, 8'h10);
    periodic_tick_pulse <= 1'b1;
    @(posedge pclk);
    periodic_tick_pulse <= 1'b0;
    rd(6'h20, r);
    chk_reg("tick flags", 8'h50, r);
    wr(6'h20, 8'h40);
    i_mis_cpu_model.pulse(2);
    take(16'h0000);
    wr(6'h20, 8'h20);
    x = rnd();
    i2c_flags <= x[3:0] | 4'h1;
    i2c_enables <= 4'hF;
    prog_timer_flags <= x[8:4] | 5'h01;
    prog_timer_enables <= 5'h1F;
    tick_count <= 8'h00;
    take(16'h3FF8);
    wr(6'h20, 8'h80);
    i_mis_cpu_model.pulse(2);
    take(16'h3FF6);
    i2c_enables <= 4'h0;
    i_mis_cpu_model.pulse(2);
    take(16'h3FF4);
    i_mis_cpu_model.pulse(1);
    take(16'h3FFC);
    i_mis_cpu_model.pulse(2);
    i_mis_cpu_model.pulse(1);
    take(16'h3FF4);
    take(16'h3FFC);
    prog_timer_flags <= 5'h00;
    i_mis_cpu_model.pulse(2);
    i_mis_cpu_model.pulse(1);
    i2c_enables <= 4'hF;
    take(16'h3FFC);
    i2c_enables <= 4'h0;
    i_mis_cpu_model.pulse(2);
    i_mis_cpu_model.pulse(4);
    repeat (2) @(posedge pclk);
    chk_reg("wait clocks", 8'h0B, clks());
    prog_timer_flags <= 5'h01;
    repeat (4) @(posedge pclk);
    chk_reg("wait exit", 8'h0F, clks());
    prog_timer_flags <= 5'h00;
    i_mis_cpu_model.pulse(3);
    repeat (2) @(posedge pclk);
    chk_reg("stop clocks", 8'h00, clks());
    ext_request_pin_a_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk_reg("stop exit", 8'h0F, clks());
    take(16'h3FFA);
    i_mis_cpu_model.pulse(2);
    take(16'h0000);
    ext_request_pin_a_n <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_request_pin_a_n <= 1'b0;
    repeat (4) @(posedge pclk);
    i_mis_cpu_model.pulse(2);
    take(16'h3FFA);
    // Fresh reset reopens the option bit: pin a held low keeps requesting
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    i_mis_cpu_model.pulse(2);
    take(16'h3FFA);
    i_mis_cpu_model.pulse(2);
    take(16'h3FFA);
    finish_test();
  end
endmodule

bind mis_irq_seq mis_irq_seq_checker i_mis_irq_seq_checker (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .cpu_instr_done, .cpu_stop_req, .vec_take, .stack_save, .vec_hi_addr, .vec_lo_addr, .mask_bit,
  .osc_enable, .cpu_clk_enable, .tick_clk_enable, .prog_timer_clk_enable);
